// file: core/local_reset_consts.svh
`ifndef LOCAL_RESET_CONSTS_SVH
`define LOCAL_RESET_CONSTS_SVH
// clock rate in kHz and period in ns
`define LRG_CLK_KHZ 20000
`define LRG_CLK_PERIOD_NS 50
// cycles local reset is stretched after every source falls
`define LRG_HOLD_CYCLES 4
// width of the hold counter
`define LRG_HOLD_W 3
// reset value of the hold counter after power-up
`define LRG_HOLD_RST 3'h4
// number of reset sources
`define LRG_NUM_SRC 5
// source bit positions
`define LRG_SRC_WDOG 0
`define LRG_SRC_SWITCH 1
`define LRG_SRC_REMOTE 2
`define LRG_SRC_VME 3
`define LRG_SRC_POWER 4
`endif

// file: core/local_reset_generator.sv
// What this block does
// - local reset asserted whenever full system reset is asserted
// - watchdog expiry asserts local reset
// - front-panel switch resets only while system-controller function disabled
// - remote board-control reset bit asserts local reset
// - vme system reset and power-up also reset; five board sources plus full system reset
// - vme accesses ignored, no slave response, during local reset
// - ignored access ends in bus error when global timer expires
// - local reset aborts local bus cycle in progress, bridged too
`timescale 1ns/1ps
`include "local_reset_consts.svh"
module local_reset_generator #(
  parameter int HOLD_CYCLES = `LRG_HOLD_CYCLES
) (
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic full_system_reset_in,
  input  wire logic wdog_expired_in,
  input  wire logic panel_switch_in,
  input  wire logic sysctl_enabled_in,
  input  wire logic remote_reset_bit_in,
  input  wire logic vme_sysreset_in,
  input  wire logic power_up_reset_in,
  input  wire logic vme_access_in,
  input  wire logic vme_ack_in,
  input  wire logic bus_timer_en_in,
  input  wire logic bus_timer_expired_in,
  input  wire logic local_cycle_in,
  output logic      local_bus_reset_out,
  output logic      vme_ack_out,
  output logic      vme_berr_out,
  output logic      local_abort_out
);
  import local_reset_pkg::*;

  // one bit per board source; full system reset is kept apart
  logic [`LRG_NUM_SRC-1:0] src;
  logic                    sw_masked;
  logic                    any_src;

  // sequencer registers and their next values
  seq_state_t              state_ff;
  seq_state_t              nxt_state;
  logic [`LRG_HOLD_W-1:0]  hold_ff;
  logic [`LRG_HOLD_W-1:0]  nxt_hold;
  logic [`LRG_HOLD_W-1:0]  hold_load;
  logic                    hold_done;
  logic                    loc_rst_ff;
  logic                    nxt_loc_rst;

  // slave answer registers and their next values
  logic                    ack_ff;
  logic                    nxt_ack;
  logic                    berr_ff;
  logic                    nxt_berr;
  logic                    pending_ff;
  logic                    nxt_pending;
  logic                    ignore_access;
  logic                    timer_fired;

  // local cycle abort register
  logic                    abort_ff;
  logic                    nxt_abort;

  assign src[`LRG_SRC_WDOG]   = wdog_expired_in;

  // switch masked by controller
  // with the controller function on, the switch already drives the bus-wide reset
  assign sw_masked            = panel_switch_in & ~sysctl_enabled_in;
  assign src[`LRG_SRC_SWITCH] = sw_masked;

  // is the remote master's discipline; nothing here tells a hung bus from a busy one
  assign src[`LRG_SRC_REMOTE] = remote_reset_bit_in;

  assign src[`LRG_SRC_VME]    = vme_sysreset_in;
  assign src[`LRG_SRC_POWER]  = power_up_reset_in;

  // system reset included
  // local reset is the smaller reset, so anything wider must pull it too
  assign any_src = (|src) | full_system_reset_in;

  // hold length, cut to the counter width on purpose
  assign hold_load = HOLD_CYCLES[`LRG_HOLD_W-1:0];

  // last hold edge; a load of zero behaves like a load of one
  assign hold_done = (hold_ff <= `LRG_HOLD_W'(1));

  // next sequencer state; release stretched so short glitches still give a full reset
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RESET: begin
        if (!any_src) begin
          nxt_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (any_src) begin
          nxt_state = ST_RESET; // restart the stretch
        end else if (hold_done) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (any_src) begin
          nxt_state = ST_RESET;
        end
      end
      default: begin
        nxt_state = ST_RESET; // unused code falls back to reset
      end
    endcase
  end

  // next hold count; reloaded while a source stands, counted down once all are gone
  always_comb begin
    nxt_hold = hold_ff;
    case (state_ff)
      ST_RESET: begin
        nxt_hold = hold_load;
      end
      ST_HOLD: begin
        if (!any_src && !hold_done) begin
          nxt_hold = hold_ff - `LRG_HOLD_W'(1);
        end
      end
      ST_RUN: begin
        nxt_hold = hold_ff;
      end
      default: begin
        nxt_hold = hold_load;
      end
    endcase
  end

  // next local reset level
  always_comb begin
    nxt_loc_rst = loc_rst_ff;
    case (state_ff)
      ST_RESET: begin
        nxt_loc_rst = 1'b1;
      end
      ST_HOLD: begin
        if (!any_src && hold_done) begin
          nxt_loc_rst = 1'b0;
        end
      end
      ST_RUN: begin
        if (any_src) begin
          nxt_loc_rst = 1'b1;
        end
      end
      default: begin
        nxt_loc_rst = 1'b1;
      end
    endcase
  end

  // sequencer state register
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_ff <= ST_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // hold counter
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      hold_ff <= `LRG_HOLD_RST;
    end else begin
      hold_ff <= nxt_hold;
    end
  end

  // local reset register
  // one flop feeds every local consumer, so all leave reset on the same edge
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      loc_rst_ff <= 1'b1;
    end else begin
      loc_rst_ff <= nxt_loc_rst;
    end
  end

  // ignored access test
  // an access begun in reset stays ignored to its end; acking its tail would answer half a cycle
  assign ignore_access = loc_rst_ff | pending_ff;

  assign nxt_ack = vme_ack_in & ~ignore_access;

  assign timer_fired = bus_timer_en_in & bus_timer_expired_in;

  // error for ignored access
  // without an enabled timer the master simply waits; nothing here can end its cycle
  assign nxt_berr = vme_access_in & ignore_access & timer_fired;

  // mark an access that starts while in reset; cleared when the access ends
  always_comb begin
    nxt_pending = pending_ff;
    if (!vme_access_in) begin
      nxt_pending = 1'b0;
    end else if (loc_rst_ff) begin
      nxt_pending = 1'b1;
    end
  end

  // acknowledge register
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= nxt_ack;
    end
  end

  // bus error register
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      berr_ff <= 1'b0;
    end else begin
      berr_ff <= nxt_berr;
    end
  end

  // ignored-access marker
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pending_ff <= 1'b0;
    end else begin
      pending_ff <= nxt_pending;
    end
  end

  // abort running cycle
  // a bridged cycle cut this way can leave the far bus confused; software must avoid it
  assign nxt_abort = local_cycle_in & any_src;

  // abort register
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      abort_ff <= 1'b0;
    end else begin
      abort_ff <= nxt_abort;
    end
  end

  // outputs straight from their flops
  assign local_bus_reset_out = loc_rst_ff;
  assign vme_ack_out         = ack_ff;
  assign vme_berr_out        = berr_ff;
  assign local_abort_out     = abort_ff;
endmodule : local_reset_generator

// file: core/local_reset_pkg.sv
package local_reset_pkg;
  // local reset state
  typedef enum logic [1:0] {
    ST_RESET,
    ST_HOLD,
    ST_RUN
  } seq_state_t;
endpackage : local_reset_pkg

// file: verification/local_reset_generator_bench.sv
`timescale 1ns/1ps
module local_reset_generator_bench;
  localparam int HOLD = 4;
  logic clk_in = 0, sys_rst_in = 1, sysctl_enabled_in = 0, bus_timer_en_in = 0, local_cycle_in = 0, go = 0;
  logic acc, tex, local_bus_reset_out, vme_ack_out, vme_berr_out, local_abort_out, sa, sb;
  logic [5:0] s = 6'h00;
  int n_fail = 0, checks_done = 0, i, k;
  local_reset_generator #(.HOLD_CYCLES(HOLD)) uut(.*, .full_system_reset_in(s[0]), .wdog_expired_in(s[1]),
    .panel_switch_in(s[2]), .remote_reset_bit_in(s[3]), .vme_sysreset_in(s[4]), .power_up_reset_in(s[5]),
    .vme_access_in(acc), .vme_ack_in(acc), .bus_timer_expired_in(tex));
  vme_master_model far(.clk_in, .start_in(go), .access_out(acc), .timer_out(tex));
  initial forever #25 clk_in = ~clk_in;
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin n_fail++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end
  endtask : chk
  task tick(input int n); repeat (n) @(negedge clk_in); endtask : tick
  task results;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  // bounded wait for release; k counts falling edges
  task rel;
    k = 0;
    while (local_bus_reset_out !== 1'b0 && k < 20) begin tick(1); k++; end
    if (k == 20) begin n_fail++; results; end
  endtask : rel
  // each source alone; switch ignored while system control enabled
  task t_src;
    for (i = 0; i < 6; i++) begin
      s = 6'h01 << i;
      tick(2);
      chk(local_bus_reset_out, 8'h01);
      s = 6'h00;
      rel;
      chk(8'(k), 8'(HOLD + 1));
    end
    sysctl_enabled_in = 1;
    s = 6'h04;
    tick(8);
    chk(local_bus_reset_out, 8'h00);
    {s, sysctl_enabled_in} = 7'h00;
    $display("source test done");
  endtask : t_src
  // access in run, then in reset with timer off and on
  task t_vme;
    go = 1;
    tick(1);
    go = 0;
    tick(1);
    chk(vme_ack_out, 8'h01);
    tick(4);
    for (i = 0; i < 2; i++) begin
      bus_timer_en_in = i[0];
      s[1] = 1;
      tick(1);
      go = 1;
      tick(1);
      go = 0;
      {sa, sb} = 2'b00;
      repeat (5) begin tick(1); sa |= vme_ack_out; sb |= vme_berr_out; end
      chk({sa, sb}, {1'b0, i[0]});
      s[1] = 0;
      rel;
    end
    local_cycle_in = 1;
    s[0] = 1;
    tick(1);
    chk(local_abort_out, 8'h01);
    {s[0], local_cycle_in} = 2'b00;
    rel;
    $display("bus test done");
  endtask : t_vme
  // access first seen on the release edge stays ignored to its end
  task t_late;
    bus_timer_en_in = 1;
    s[1] = 1;
    tick(1);
    s[1] = 0;
    tick(3);
    go = 1;
    tick(1);
    go = 0;
    {sa, sb} = 2'b00;
    repeat (5) begin tick(1); sa |= vme_ack_out; sb |= vme_berr_out; end
    chk({sa, sb}, 8'h01);
    chk(local_bus_reset_out, 8'h00);
    bus_timer_en_in = 0;
    $display("late access test done");
  endtask : t_late
  initial begin
    tick(6);
    sys_rst_in = 0;
    rel;
    t_src;
    t_vme;
    t_late;
    results;
  end
endmodule : local_reset_generator_bench

// file: verification/lrg_properties.sv
`timescale 1ns/1ps
module lrg_checker(input wire logic clk_in, sys_rst_in, full_system_reset_in, wdog_expired_in,
  panel_switch_in, sysctl_enabled_in, remote_reset_bit_in, vme_sysreset_in, power_up_reset_in,
  vme_access_in, vme_ack_in, bus_timer_en_in, bus_timer_expired_in, local_cycle_in,
  local_bus_reset_out, vme_ack_out, vme_berr_out, local_abort_out);
  // any source; the switch only counts without system control
  wire logic src = full_system_reset_in | wdog_expired_in | (panel_switch_in & ~sysctl_enabled_in)
    | remote_reset_bit_in | vme_sysreset_in | power_up_reset_in;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence quiet; !src [*7]; endsequence
  sequence late_access; vme_access_in && local_bus_reset_out ##1 vme_access_in; endsequence
  a_source_asserts: assert property (src |=> local_bus_reset_out) else $error("src");
  a_hold_stretch: assert property (!src && $past(src) |=> local_bus_reset_out [*4]) else $error("hold");
  a_clean_release: assert property (quiet |-> !local_bus_reset_out) else $error("rel");
  a_ack_blocked: assert property (local_bus_reset_out |=> !vme_ack_out) else $error("ack");
  a_ack_passes: assert property ($rose(vme_access_in) && vme_ack_in && !local_bus_reset_out && !src
    |=> vme_ack_out) else $error("ack run");
  a_ack_late: assert property (late_access |=> !vme_ack_out) else $error("ack late");
  a_berr_timer: assert property (local_bus_reset_out && vme_access_in && bus_timer_en_in
    && bus_timer_expired_in |=> vme_berr_out) else $error("berr");
  a_berr_gated: assert property (!bus_timer_en_in |=> !vme_berr_out) else $error("berr off");
  a_abort_cycle: assert property (local_cycle_in && src |=> local_abort_out) else $error("abort");
endmodule : lrg_checker
bind local_reset_generator lrg_checker chk_i(.*);

// file: verification/vme_master_model.sv
`timescale 1ns/1ps
// remote master: one 3-cycle access, global timer runs out on its last cycle
module vme_master_model(input wire logic clk_in, input wire logic start_in,
  output logic access_out, output logic timer_out);
  logic [1:0] cnt_ff = 2'h0;
  always_ff @(posedge clk_in) cnt_ff <= start_in ? 2'h3 : cnt_ff - {1'b0, cnt_ff != 2'h0};
  assign access_out = cnt_ff != 2'h0;
  assign timer_out = cnt_ff == 2'h1;
endmodule : vme_master_model
